//--- logic/rtp_priority_control.sv
// token ring priority control in the repeat path, with avalon-mm registers
// assumes rx strobes are synchronous to core_clk, one ring bit per cycle
//
// What this block does
// - insert nine-bit delay to rewrite token priority
// - delay only in path while machine needs it
// - four-deep stack of raised priorities
// - four-deep stack of original priorities
// - at most four nested priority raises supported
// - enable on new token release, until remove
// - push: stack levels, send reservation as priority
// - pop: restore original priority, pop both stacks
// - replace: raised top and priority become reservation
// - priority below raised top: error, clear stacks
// - token leaving with empty stacks: remove delay
// - empty state after enable and after clear
// - operation chosen from four comparisons plus flags
// - non-empty token cases: clear, replace, pop, push
// - empty: push or remove; frames mostly idle
// - flag code violation keeps machine idle
// - flag zero token, one frame
// - three-bit priority, zero lowest, seven highest
// - raise reservation only if access priority higher
`timescale 1ns/100ps
`default_nettype none

module rtp_priority_control
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic rx_bit,
   input wire logic rx_code_violation,
   input wire logic rx_start_delim,
   input wire logic rx_end_delim,
   input wire logic new_token_release,
   output logic tx_bit,
   output logic delay_inserted,
   output logic machine_enabled,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   logic [rtp_pkg::DELAY_BITS-1:0] dly;
   logic [rtp_pkg::DELAY_BITS-1:0] next_dly;
   logic in_hdr;
   logic [3:0] hdr_idx;
   logic flag_cv;
   logic remove_pending;
   logic draining;
   logic [3:0] drain_cnt;
   logic [rtp_pkg::DEPTH_W-1:0] depth;
   logic [2:0] raised_stk [rtp_pkg::STACK_DEPTH];
   logic [2:0] orig_stk [rtp_pkg::STACK_DEPTH];
   logic [2:0] access_pri;
   logic queued;
   rtp_pkg::rtp_op_type last_op;
   rtp_pkg::rtp_cmp_type cmp_st;

   // decision terms
   rtp_pkg::rtp_hdr_type hdr_in;
   rtp_pkg::rtp_hdr_type hdr_out;
   rtp_pkg::rtp_op_type op;
   logic do_remove;
   logic decide;
   logic [2:0] res_eff;
   logic [2:0] new_top;
   logic [2:0] old_top;
   logic [1:0] top_idx;
   logic lt_res;
   logic eq_new;
   logic lt_new;
   logic gt_old;
   logic bypass_bit;
   logic [1:0] res_pos;

   assign decide = in_hdr && hdr_idx == rtp_pkg::HDR_LAST_IDX
      && delay_inserted;
   assign top_idx = 2'(depth - 3'h1);

   always_comb
   begin
      hdr_in = rtp_pkg::rtp_hdr_type'({dly[6:0], rx_bit});
      res_eff = hdr_in.reservation_level;
      if (queued && access_pri > hdr_in.reservation_level)
      begin
         res_eff = access_pri;
      end
      new_top = (depth != 3'h0) ? raised_stk[top_idx] : 3'h0;
      old_top = (depth != 3'h0) ? orig_stk[top_idx] : 3'h0;
      lt_res = hdr_in.priority_indicator < res_eff;
      eq_new = hdr_in.priority_indicator == new_top;
      lt_new = hdr_in.priority_indicator < new_top;
      gt_old = res_eff > old_top;
      op = rtp_pkg::OP_IDLE;
      do_remove = 1'b0;
      if (!flag_cv)
      begin
         if (depth == 3'h0)
         begin
            if (hdr_in.token_frame_flag == rtp_pkg::FLAG_TOKEN)
            begin
               if (lt_res && gt_old)
               begin
                  op = rtp_pkg::OP_PUSH;
               end
               else
               begin
                  do_remove = 1'b1;
               end
            end
         end
         else if (lt_new)
         begin
            op = rtp_pkg::OP_CLEAR;
            do_remove = hdr_in.token_frame_flag == rtp_pkg::FLAG_TOKEN;
         end
         else if (hdr_in.token_frame_flag == rtp_pkg::FLAG_TOKEN)
         begin
            if (eq_new)
            begin
               if (gt_old)
               begin
                  op = rtp_pkg::OP_REPLACE;
               end
               else
               begin
                  op = rtp_pkg::OP_POP;
                  do_remove = depth == 3'h1;
               end
            end
            else if (lt_res && gt_old)
            begin
               op = rtp_pkg::OP_PUSH;
            end
         end
      end
      // a fifth nested raise is not supported
      if (op == rtp_pkg::OP_PUSH && depth == 3'(rtp_pkg::STACK_DEPTH))
      begin
         op = rtp_pkg::OP_IDLE;
      end
      hdr_out = hdr_in;
      hdr_out.reservation_level = res_eff;
      unique case (op)
         rtp_pkg::OP_PUSH, rtp_pkg::OP_REPLACE:
         begin
            hdr_out.priority_indicator = res_eff;
            hdr_out.reservation_level = 3'h0;
            hdr_out.monitor_mark_bit = 1'b0;
         end
         rtp_pkg::OP_POP:
         begin
            hdr_out.priority_indicator = old_top;
            hdr_out.monitor_mark_bit = 1'b0;
         end
         rtp_pkg::OP_IDLE, rtp_pkg::OP_CLEAR:
         begin
         end
      endcase
   end

   // delay line with in-place header rewrite
   always_comb
   begin
      next_dly = {dly[rtp_pkg::DELAY_BITS-2:0], rx_bit};
      if (decide)
      begin
         next_dly[rtp_pkg::HDR_BITS-1:0] = hdr_out;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         dly <= '0;
      end
      else
      begin
         dly <= next_dly;
      end
   end

   // header position tracking
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         in_hdr <= 1'b0;
         hdr_idx <= 4'h0;
         flag_cv <= 1'b0;
      end
      else if (rx_start_delim)
      begin
         in_hdr <= 1'b1;
         hdr_idx <= 4'h0;
         flag_cv <= 1'b0;
      end
      else if (in_hdr)
      begin
         hdr_idx <= hdr_idx + 4'h1;
         if (hdr_idx == rtp_pkg::HDR_LAST_IDX)
         begin
            in_hdr <= 1'b0;
         end
         if (hdr_idx == rtp_pkg::FLAG_BIT_IDX && rx_code_violation)
         begin
            flag_cv <= 1'b1;
         end
      end
   end

   // serial reservation raise while no delay is inserted
   assign res_pos = 2'(hdr_idx - rtp_pkg::RES_FIRST_IDX);

   always_comb
   begin
      bypass_bit = rx_bit;
      if (in_hdr && queued && hdr_idx >= rtp_pkg::RES_FIRST_IDX)
      begin
         unique case (cmp_st)
            rtp_pkg::CMP_EQUAL:
            begin
               bypass_bit = rx_bit | access_pri[2'd2 - res_pos];
            end
            rtp_pkg::CMP_KEEP_RX:
            begin
               bypass_bit = rx_bit;
            end
            rtp_pkg::CMP_USE_ACCESS:
            begin
               bypass_bit = access_pri[2'd2 - res_pos];
            end
            default:
            begin
               bypass_bit = rx_bit;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cmp_st <= rtp_pkg::CMP_EQUAL;
      end
      else if (rx_start_delim)
      begin
         cmp_st <= rtp_pkg::CMP_EQUAL;
      end
      else if (in_hdr && hdr_idx >= rtp_pkg::RES_FIRST_IDX
         && cmp_st == rtp_pkg::CMP_EQUAL)
      begin
         if (rx_bit && !access_pri[2'd2 - res_pos])
         begin
            cmp_st <= rtp_pkg::CMP_KEEP_RX;
         end
         else if (!rx_bit && access_pri[2'd2 - res_pos])
         begin
            cmp_st <= rtp_pkg::CMP_USE_ACCESS;
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tx_bit <= 1'b0;
      end
      else
      begin
         tx_bit <= delay_inserted ? dly[rtp_pkg::DELAY_BITS-1] : bypass_bit;
      end
   end

   // enable, remove and delay drain
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         machine_enabled <= 1'b0;
         delay_inserted <= 1'b0;
         remove_pending <= 1'b0;
         draining <= 1'b0;
         drain_cnt <= 4'h0;
      end
      else if (new_token_release)
      begin
         machine_enabled <= 1'b1;
         delay_inserted <= 1'b1;
         remove_pending <= 1'b0;
         draining <= 1'b0;
      end
      else
      begin
         if (decide && do_remove)
         begin
            remove_pending <= 1'b1;
         end
         if (remove_pending && rx_end_delim)
         begin
            remove_pending <= 1'b0;
            draining <= 1'b1;
            drain_cnt <= 4'h0;
         end
         if (draining)
         begin
            drain_cnt <= drain_cnt + 4'h1;
            if (drain_cnt == rtp_pkg::DRAIN_COUNT - 4'h1)
            begin
               draining <= 1'b0;
               delay_inserted <= 1'b0;
               machine_enabled <= 1'b0;
            end
         end
      end
   end

   // stack depth shared by both stacks
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         depth <= 3'h0;
         last_op <= rtp_pkg::OP_IDLE;
      end
      else if (new_token_release)
      begin
         depth <= 3'h0;
      end
      else if (decide)
      begin
         last_op <= op;
         unique case (op)
            rtp_pkg::OP_PUSH: depth <= depth + 3'h1;
            rtp_pkg::OP_POP: depth <= depth - 3'h1;
            rtp_pkg::OP_CLEAR: depth <= 3'h0;
            rtp_pkg::OP_IDLE, rtp_pkg::OP_REPLACE:
            begin
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < rtp_pkg::STACK_DEPTH; gi++)
      begin : g_entry
         always_ff @(posedge core_clk or negedge nrst)
         begin
            if (!nrst)
            begin
               raised_stk[gi] <= 3'h0;
               orig_stk[gi] <= 3'h0;
            end
            else if (decide && op == rtp_pkg::OP_PUSH
               && depth == 3'(gi))
            begin
               raised_stk[gi] <= res_eff;
               orig_stk[gi] <= hdr_in.priority_indicator;
            end
            else if (decide && op == rtp_pkg::OP_REPLACE
               && top_idx == 2'(gi))
            begin
               raised_stk[gi] <= res_eff;
            end
         end
      end
   endgenerate

   // avalon-mm slave, one wait cycle per access
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end
      else if ((avs_read || avs_write) && avs_waitrequest)
      begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= 32'h0000_0000;
         if (avs_read && avs_address == rtp_pkg::CTRL_OFFSET)
         begin
            avs_readdata[rtp_pkg::CTRL_ACCESS_LSB +: 3] <= access_pri;
            avs_readdata[rtp_pkg::CTRL_QUEUED_BIT] <= queued;
         end
         else if (avs_read && avs_address == rtp_pkg::STATUS_OFFSET)
         begin
            avs_readdata[rtp_pkg::STAT_DEPTH_LSB +: 3] <= depth;
            avs_readdata[rtp_pkg::STAT_ENABLED_BIT] <= machine_enabled;
            avs_readdata[rtp_pkg::STAT_DELAY_BIT] <= delay_inserted;
            avs_readdata[rtp_pkg::STAT_NEW_TOP_LSB +: 3] <= new_top;
            avs_readdata[rtp_pkg::STAT_OLD_TOP_LSB +: 3] <= old_top;
            avs_readdata[rtp_pkg::STAT_LAST_OP_LSB +: 3] <= last_op;
         end
      end
      else
      begin
         avs_waitrequest <= 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         access_pri <= rtp_pkg::CTRL_ACCESS_RESET;
         queued <= 1'b0;
      end
      else if (avs_write && !avs_waitrequest
         && avs_address == rtp_pkg::CTRL_OFFSET && avs_byteenable[0])
      begin
         queued <= avs_writedata[rtp_pkg::CTRL_QUEUED_BIT];
         if (avs_writedata[rtp_pkg::CTRL_ACCESS_LSB +: 3]
            <= rtp_pkg::MAX_ACCESS_PRI)
         begin
            access_pri <= avs_writedata[rtp_pkg::CTRL_ACCESS_LSB +: 3];
         end
      end
   end

endmodule

`default_nettype wire

//--- logic/rtp_pkg.sv
// package for the ring token priority control block
// assumes a serial ring bit stream clocked at one bit per core_clk
package rtp_pkg;

   // priority levels and stack sizes
   localparam int PRI_W = 3;
   localparam int STACK_DEPTH = 4;
   localparam int DEPTH_W = 3;
   localparam int DELAY_BITS = 9;
   localparam int HDR_BITS = 8;
   localparam logic [3:0] HDR_LAST_IDX = 4'h7;
   localparam logic [3:0] FLAG_BIT_IDX = 4'h3;
   localparam logic [3:0] RES_FIRST_IDX = 4'h5;
   localparam logic [3:0] DRAIN_COUNT = 4'h9;
   localparam logic [2:0] MAX_ACCESS_PRI = 3'h3;

   // token / frame flag encoding
   localparam logic FLAG_TOKEN = 1'b0;
   localparam logic FLAG_FRAME = 1'b1;

   // register map, byte offsets
   localparam logic [3:0] CTRL_OFFSET = 4'h0;
   localparam logic [3:0] STATUS_OFFSET = 4'h4;

   // control register fields
   localparam int CTRL_ACCESS_LSB = 0;
   localparam int CTRL_QUEUED_BIT = 4;
   localparam logic [2:0] CTRL_ACCESS_RESET = 3'h0;

   // status register fields
   localparam int STAT_DEPTH_LSB = 0;
   localparam int STAT_ENABLED_BIT = 4;
   localparam int STAT_DELAY_BIT = 5;
   localparam int STAT_NEW_TOP_LSB = 8;
   localparam int STAT_OLD_TOP_LSB = 12;
   localparam int STAT_LAST_OP_LSB = 16;

   // header byte layout, first bit sent is pri[2]
   typedef struct packed {
      logic [2:0] priority_indicator;
      logic token_frame_flag;
      logic monitor_mark_bit;
      logic [2:0] reservation_level;
   } rtp_hdr_type;

   typedef enum logic [2:0] {
      OP_IDLE,
      OP_PUSH,
      OP_POP,
      OP_REPLACE,
      OP_CLEAR
   } rtp_op_type;

   // serial comparator for on-the-fly reservation raise
   typedef enum logic [1:0] {
      CMP_EQUAL,
      CMP_KEEP_RX,
      CMP_USE_ACCESS
   } rtp_cmp_type;

endpackage

//--- dv/rtp_priority_control_properties.sv
// port checker for the ring token priority control block
// assumes bind onto rtp_priority_control, single core_clk domain
`timescale 1ns/100ps
`default_nettype none
module rtp_priority_control_properties
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic rx_bit,
   input wire logic rx_end_delim,
   input wire logic rx_start_delim,
   input wire logic new_token_release,
   input wire logic tx_bit,
   input wire logic delay_inserted,
   input wire logic machine_enabled,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   logic [3:0] since_end;
   logic [3:0] since_start;
   logic req;
   logic unmapped;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   assign req = avs_read || avs_write;
   assign unmapped = avs_address != rtp_pkg::CTRL_OFFSET &&
      avs_address != rtp_pkg::STATUS_OFFSET;
   // edges since the last end delimiter, saturating
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         since_end <= 4'hF;
      else if (rx_end_delim)
         since_end <= 4'h0;
      else if (since_end != 4'hF)
         since_end <= since_end + 4'h1;
   end
   // edges since the last start delimiter, saturating
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         since_start <= 4'hF;
      else if (rx_start_delim)
         since_start <= 4'h0;
      else if (since_start != 4'hF)
         since_start <= since_start + 4'h1;
   end
   // header bits may carry a raised reservation, so skip the header
   a_bypass_one_bit: assert property (
      !delay_inserted && !$past(delay_inserted) && $past(nrst)
      && since_start >= 4'hA
      |-> tx_bit == $past(rx_bit)) else $error("bypass bit not repeated");
   a_release_enables: assert property (
      new_token_release |=> machine_enabled && delay_inserted)
      else $error("release did not enable machine");
   a_rise_on_release: assert property (
      $rose(machine_enabled) |-> $past(new_token_release))
      else $error("machine enabled without release");
   a_delay_with_enable: assert property (
      delay_inserted == machine_enabled)
      else $error("delay and enable disagree");
   a_drop_after_drain: assert property (
      $fell(machine_enabled) |-> since_end >= 4'h8 && since_end <= 4'hB)
      else $error("removal not tied to end delimiter drain");
   a_wait_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_answer_next: assert property (
      req && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer not one cycle after request");
   a_no_stray_ack: assert property (
      !req |=> avs_waitrequest) else $error("answer without request");
   a_unmapped_zero: assert property (
      !avs_waitrequest && avs_read && unmapped |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_access_legal: assert property (
      !avs_waitrequest && avs_read && avs_address == rtp_pkg::CTRL_OFFSET
      |-> avs_readdata[2:0] <= rtp_pkg::MAX_ACCESS_PRI)
      else $error("access priority above limit");
   c_release: cover property (new_token_release);
   c_remove: cover property ($fell(machine_enabled));
   c_status: cover property (!avs_waitrequest && avs_read);
endmodule
bind rtp_priority_control rtp_priority_control_properties chk_u
(
   .core_clk, .nrst, .rx_bit, .rx_end_delim, .rx_start_delim,
   .new_token_release, .tx_bit,
   .delay_inserted, .machine_enabled, .avs_address, .avs_read, .avs_write,
   .avs_readdata, .avs_waitrequest
);
`default_nettype wire

//--- dv/rtp_ring_station.sv
// upstream ring station model feeding the receive side
// assumes one ring bit per core_clk, changed just after each edge
`timescale 1ns/100ps
`default_nettype none
module rtp_ring_station
(
   input wire logic core_clk,
   input wire logic tx_bit,
   output logic rx_bit,
   output logic rx_code_violation,
   output logic rx_start_delim,
   output logic rx_end_delim
);
   logic busy;
   initial
   begin
      busy = 1'b0;
      rx_bit = 1'b0;
      rx_code_violation = 1'b0;
      rx_start_delim = 1'b0;
      rx_end_delim = 1'b0;
   end
   // fill toggles every bit so a stale value never passes
   always @(posedge core_clk)
   begin
      if (!busy)
         rx_bit <= ~rx_bit;
   end
   // header, fill, end delimiter; grabs the delayed header
   task send(input rtp_pkg::rtp_hdr_type h, input logic cv,
      output logic [7:0] seen);
      int i;
      busy = 1'b1;
      @(posedge core_clk);
      rx_start_delim <= 1'b1;
      for (i = 0; i < 19; i++)
      begin
         @(posedge core_clk);
         if (i >= 11)
            seen[18 - i] = tx_bit;
         rx_start_delim <= 1'b0;
         rx_end_delim <= (i == 9);
         rx_code_violation <= cv && (i == 3);
         rx_bit <= (i < 8) ? h[7 - i] : ~rx_bit;
      end
      busy <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the ring token priority control block
// assumes the ring station model and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic core_clk, nrst, rx_bit, rx_code_violation, rx_start_delim;
   logic rx_end_delim, new_token_release, tx_bit, delay_inserted;
   logic machine_enabled, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address, avs_byteenable;
   logic [31:0] avs_writedata, avs_readdata, rq;
   logic [2:0] acc, nw[$], od[$];
   logic qd, en;
   int err_total, checked, seed, k;
   rtp_priority_control dut_u
   (
      .core_clk, .nrst, .rx_bit, .rx_code_violation, .rx_start_delim,
      .rx_end_delim, .new_token_release, .tx_bit, .delay_inserted,
      .machine_enabled, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest
   );
   rtp_ring_station ring_u
   (
      .core_clk, .tx_bit, .rx_bit, .rx_code_violation, .rx_start_delim,
      .rx_end_delim
   );
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task complete_run;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      rq = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50)
      begin
         err_total++;
         complete_run;
      end
   endtask
   task ctrl(input logic [2:0] a, input logic q1);
      bus(1'b1, rtp_pkg::CTRL_OFFSET, {27'h0, q1, 1'b0, a});
      if (avs_byteenable[0])
         qd = q1;
      if (avs_byteenable[0] && a <= rtp_pkg::MAX_ACCESS_PRI)
         acc = a;
      bus(1'b0, rtp_pkg::CTRL_OFFSET, 32'h0);
      chk(rq, {27'h0, qd, 1'b0, acc});
   endtask
   task rel;
      @(posedge core_clk);
      new_token_release <= 1'b1;
      @(posedge core_clk);
      new_token_release <= 1'b0;
      en = 1'b1;
      nw.delete();
      od.delete();
   endtask
   task frame(input rtp_pkg::rtp_hdr_type hd, input logic cv);
      rtp_pkg::rtp_hdr_type o;
      rtp_pkg::rtp_op_type op;
      logic [7:0] seen;
      logic [31:0] m;
      logic [2:0] r, p, nt, ot;
      logic mt, rem, was;
      r = (qd && acc > hd.reservation_level) ? acc : hd.reservation_level;
      p = hd.priority_indicator;
      mt = nw.size() == 0;
      nt = mt ? 3'h0 : nw[nw.size() - 1];
      ot = mt ? 3'h0 : od[od.size() - 1];
      o = hd;
      o.reservation_level = r;
      op = rtp_pkg::OP_IDLE;
      rem = 1'b0;
      was = en;
      if (en && !cv)
      begin
         if (hd.token_frame_flag == rtp_pkg::FLAG_FRAME)
            op = (!mt && p < nt) ? rtp_pkg::OP_CLEAR : op;
         else if (!mt && p < nt)
            op = rtp_pkg::OP_CLEAR;
         else if (!mt && p == nt)
            op = (r > ot) ? rtp_pkg::OP_REPLACE : rtp_pkg::OP_POP;
         else if (p < r && r > ot && nw.size() < 4)
            op = rtp_pkg::OP_PUSH;
         rem = hd.token_frame_flag == rtp_pkg::FLAG_TOKEN &&
            (op == rtp_pkg::OP_CLEAR || (mt && op == rtp_pkg::OP_IDLE) ||
            (op == rtp_pkg::OP_POP && nw.size() == 1));
      end
      if (op != rtp_pkg::OP_IDLE && op != rtp_pkg::OP_CLEAR)
         o.monitor_mark_bit = 1'b0;
      if (op == rtp_pkg::OP_POP)
         o.priority_indicator = ot;
      if (op == rtp_pkg::OP_PUSH || op == rtp_pkg::OP_REPLACE)
      begin
         o.priority_indicator = r;
         o.reservation_level = 3'h0;
      end
      if (op == rtp_pkg::OP_REPLACE)
         nw[nw.size() - 1] = r;
      if (op == rtp_pkg::OP_POP)
      begin
         nw.delete(nw.size() - 1);
         od.delete(od.size() - 1);
      end
      if (op == rtp_pkg::OP_PUSH)
      begin
         od.push_back(p);
         nw.push_back(r);
      end
      if (op == rtp_pkg::OP_CLEAR)
      begin
         nw.delete();
         od.delete();
      end
      ring_u.send(hd, cv, seen);
      if (was)
         chk({24'h0, seen}, {24'h0, o});
      if (rem)
         en = 1'b0;
      // removal drains nine bits after the end delimiter
      repeat (4) @(posedge core_clk);
      bus(1'b0, rtp_pkg::STATUS_OFFSET, 32'h0);
      mt = nw.size() == 0;
      nt = mt ? 3'h0 : nw[nw.size() - 1];
      ot = mt ? 3'h0 : od[od.size() - 1];
      m = (op == rtp_pkg::OP_IDLE) ? 32'hFFF8FFFF : 32'hFFFFFFFF;
      chk(rq & m, {13'h0, op, 1'b0, ot, 1'b0, nt, 2'h0, en, en, 1'b0,
         3'(nw.size())} & m);
   endtask
   initial
   begin
      seed = 17;
      err_total = 0;
      checked = 0;
      nrst = 1'b0;
      new_token_release = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
      acc = 3'h0;
      qd = 1'b0;
      en = 1'b0;
      repeat (20) @(posedge core_clk);
      nrst <= 1'b1;
      bus(1'b0, rtp_pkg::STATUS_OFFSET, 32'h0);
      chk(rq, 32'h0);
      bus(1'b0, 4'h8, 32'h0);
      chk(rq, 32'h0);
      ctrl(3'h5, 1'b1);
      avs_byteenable <= 4'h0;
      ctrl(3'h2, 1'b0);
      avs_byteenable <= 4'hF;
      ctrl(3'h0, 1'b0);
      $display("test registers done");
      rel;
      frame(8'h06, 1'b0);
      frame(8'hC4, 1'b0);
      frame(8'h80, 1'b0);
      $display("test example done");
      rel;
      for (k = 0; k < 4; k++)
         frame({k[2:0], 2'b00, k[2:0] + 3'h1}, 1'b0);
      frame(8'hA6, 1'b0);
      frame(8'h58, 1'b0);
      frame(8'h05, 1'b1);
      frame(8'h00, 1'b0);
      $display("test nesting done");
      for (k = 0; k < 60; k++)
      begin
         if (($random(seed) & 3) == 0)
            rel;
         if ((k & 7) == 0)
            ctrl(3'($random(seed) & 3), 1'($random(seed)));
         frame(8'($random(seed)), 1'b0);
      end
      $display("test random done");
      complete_run;
   end
endmodule
`default_nettype wire
